// >>> sfc_consts.vh
// opcodes, status layout and sizes of the serial flash command front end
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFC_OP_WRITE_UNLOCK      8'h06
`define SFC_OP_WRITE_LOCK        8'h04
`define SFC_OP_IDENTITY_READ     8'h9F
`define SFC_OP_STATUS_READ       8'h05
`define SFC_OP_ARRAY_READ        8'h03
`define SFC_OP_FAST_READ         8'h0B
`define SFC_OP_PAGE_REWRITE      8'h0A
`define SFC_OP_PAGE_PROGRAM      8'h02
`define SFC_OP_PAGE_CLEAR        8'hDB
`define SFC_OP_REGION_WIPE_64K   8'hD8
`define SFC_OP_DEEP_SLEEP_ENTER  8'hB9
`define SFC_OP_DEEP_SLEEP_EXIT   8'hAB
// ----------------------------------------
// status_flags layout and reset
// ----------------------------------------
`define SFC_ST_BUSY_BIT          0
`define SFC_ST_WEL_BIT           1
`define SFC_ST_RESET             8'h00
// ----------------------------------------
// frame sizes
// ----------------------------------------
`define SFC_ADDR_BYTES           3'd3
`define SFC_ERASE_BYTES          3'd4
`define SFC_WRITE_MIN_BYTES      3'd5
`define SFC_ID_BYTES             5'd20
`define SFC_ID_CFD_FIRST         5'd4
`define SFC_ID_CFD_LEN           8'h10
`define SFC_ARRAY_AW             20
`define SFC_PAGE_BITS            8
`define SFC_SECTOR_BITS          16
`define SFC_FIFO_AW              3
`endif

// >>> sfc_front_end.v
// spi slave command front end of a page organised serial flash, with write data fifo
// Notes on behaviour
// R1 - array is 4096 pages of 256 bytes, sixteen 64 KiB sectors
// R2 - each page can be programmed, erased or written on its own
// R3 - every byte moves most significant bit first, both directions
// R4 - input bits are taken on rising serial clock edges after select falls
// R5 - opcode first; array ops take three address bytes, others none
// R6 - erases take address only; fast read adds one dummy byte
// R7 - read opcodes drive output after input; select high ends and idles
// R8 - modify, latch and sleep opcodes need a bit count multiple of eight
// R9 - array access while an internal cycle runs is ignored
// R10 - lone 06h byte sets the write enable latch
// R11 - master must set the latch before each write, program or erase
// R12 - lone 04h byte clears the write enable latch
// R13 - latch clears at reset, lock, and each accepted write or erase
// R14 - identity read sends twenty bytes on falling edges in fixed order
// R15 - sixteen customer bytes are read only, default 00h
// R16 - identity read during an internal cycle is not decoded
// R17 - status read works always and repeats the status byte
// R18 - status byte: zeros, latch in b1, busy in b0, read only
// R19 - busy reads one only while the internal engine runs
// R20 - latch at zero refuses every write, program and erase
// R21 - array read takes 24 bit address, top four ignored, data on falls
// R22 - read address increments per byte and wraps to zero
// R23 - array read during an internal cycle is rejected
// R24 - unknown opcode is ignored, output undriven, flags untouched
`timescale 1ns/1ps
`include "sfc_consts.vh"

// ----------------------------------------
// write data fifo
// ----------------------------------------
module sfc_fifo #(
	parameter W  = 8,
	parameter AW = `SFC_FIFO_AW
) (
	// clock and reset
	input  wire         ref_clk_i,
	input  wire         arst_n_i,
	// fill side
	input  wire [W-1:0] in_data_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	// drain side
	output wire [W-1:0] out_data_o,
	output wire         out_valid_o,
	input  wire         out_ready_i
);
	localparam D = 1 << AW;
	reg [W-1:0]  mem [0:D-1];
	reg [AW:0]   wr_ptr;
	reg [AW:0]   rd_ptr;
	wire         full;
	wire         empty;

	assign empty       = (wr_ptr == rd_ptr);
	assign full        = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];

	always @(posedge ref_clk_i)
	begin
		if (in_valid_i && !full)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end

	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid_i && !full)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_ready_i && !empty)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// ----------------------------------------
// command front end
// ----------------------------------------
module sfc_front_end #(
	parameter [7:0]   MFR_CODE  = 8'hA5,    // arbitrary value
	parameter [7:0]   TYPE_CODE = 8'h5A,    // arbitrary value
	parameter [7:0]   CAP_CODE  = 8'h3C,    // arbitrary value
	parameter [127:0] CFD_BYTES = 128'h0,
	parameter         FIFO_AW   = `SFC_FIFO_AW
) (
	// clock and reset
	input  wire        ref_clk_i,
	input  wire        arst_n_i,
	// serial link
	input  wire        spi_sel_n_i,
	input  wire        spi_clk_i,
	input  wire        spi_din_i,
	output reg         spi_dout_o,
	output reg         spi_dout_oe_o,
	// array read port
	output wire [19:0] mem_addr_o,
	input  wire [7:0]  mem_rdata_i,
	// internal cycle engine
	input  wire        busy_i,
	output reg         cmd_start_o,
	output reg         cmd_drop_o,
	output reg  [7:0]  cmd_op_o,
	output reg  [19:0] cmd_addr_o,
	output reg         sleep_enter_o,
	output reg         sleep_exit_o,
	// write data stream
	output wire [7:0]  wr_data_o,
	output wire        wr_valid_o,
	input  wire        wr_ready_i,
	// block state
	output reg  [7:0]  status_o,
	output reg         overrun_o
);
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_OPC   = 3'd1;
	localparam [2:0] ST_ADDR  = 3'd2;
	localparam [2:0] ST_DUMMY = 3'd3;
	localparam [2:0] ST_OUT   = 3'd4;
	localparam [2:0] ST_DATA  = 3'd5;
	localparam [2:0] ST_IGN   = 3'd6;

	localparam [1:0] SRC_STAT = 2'd0;
	localparam [1:0] SRC_ID   = 2'd1;
	localparam [1:0] SRC_ARR  = 2'd2;

	reg  [2:0]  sel_sy;
	reg  [2:0]  clk_sy;
	reg  [1:0]  din_sy;
	reg  [2:0]  state;
	reg  [6:0]  shin;
	reg  [2:0]  bit_i;
	reg  [2:0]  byte_n;
	reg  [7:0]  opc;
	reg  [23:0] addr;
	reg  [1:0]  src;
	reg  [7:0]  osh;
	reg  [2:0]  obit;
	reg  [4:0]  id_idx;
	reg         write_enable_latch;
	reg         wr_go;
	reg         push;
	reg  [7:0]  push_data;
	wire        fifo_ready;
	wire        selected;
	wire        sel_fall;
	wire        sel_rise;
	wire        clk_rise;
	wire        clk_fall;
	wire [7:0]  byte_in;
	wire        byte_done;
	wire        aligned;
	wire [7:0]  stat_byte;
	wire [7:0]  next_out;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [7:0] sfc_status;
		input w;
		input b;
		begin
			sfc_status = `SFC_ST_RESET;
			sfc_status[`SFC_ST_WEL_BIT]  = w;
			sfc_status[`SFC_ST_BUSY_BIT] = b;
		end
	endfunction

	function [7:0] sfc_id_byte;
		input [4:0]   idx;
		input [127:0] cfd;
		integer base;
		begin
			base = 127 - 8 * (idx - 4);
			case (idx)
				5'd0:    sfc_id_byte = MFR_CODE;
				5'd1:    sfc_id_byte = TYPE_CODE;
				5'd2:    sfc_id_byte = CAP_CODE;
				5'd3:    sfc_id_byte = `SFC_ID_CFD_LEN;
				default:
					if (idx < `SFC_ID_BYTES)
						sfc_id_byte = cfd[base -: 8]; // R15
					else
						sfc_id_byte = 8'h00;
			endcase
		end
	endfunction

	function sfc_is_modify;
		input [7:0] op;
		begin
			sfc_is_modify = (op == `SFC_OP_PAGE_REWRITE) || (op == `SFC_OP_PAGE_PROGRAM) ||
				(op == `SFC_OP_PAGE_CLEAR) || (op == `SFC_OP_REGION_WIPE_64K);
		end
	endfunction

	// ----------------------------------------
	// link sampling
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sel_sy <= 3'h7;
			clk_sy <= 3'h0;
			din_sy <= 2'h0;
		end
		else
		begin
			sel_sy <= {sel_sy[1:0], spi_sel_n_i};
			clk_sy <= {clk_sy[1:0], spi_clk_i};
			din_sy <= {din_sy[0], spi_din_i};
		end
	end

	assign selected  = ~sel_sy[1];
	assign sel_fall  = sel_sy[2] & ~sel_sy[1];
	assign sel_rise  = ~sel_sy[2] & sel_sy[1];
	assign clk_rise  = selected & clk_sy[1] & ~clk_sy[2]; // R4
	assign clk_fall  = selected & ~clk_sy[1] & clk_sy[2];
	assign byte_in   = {shin, din_sy[1]}; // R3
	assign byte_done = clk_rise && (bit_i == 3'd7);
	assign aligned   = (bit_i == 3'd0) && (byte_n != 3'd0); // R8
	assign stat_byte = sfc_status(write_enable_latch, busy_i); // R18 R19
	assign mem_addr_o = addr[19:0]; // R21
	assign next_out  = (src == SRC_STAT) ? stat_byte :
		(src == SRC_ID) ? sfc_id_byte(id_idx, CFD_BYTES) : mem_rdata_i;

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state         <= ST_IDLE;
			shin          <= 7'h00;
			bit_i         <= 3'd0;
			byte_n        <= 3'd0;
			opc           <= 8'h00;
			addr          <= 24'h000000;
			src           <= SRC_STAT;
			osh           <= 8'h00;
			obit          <= 3'd0;
			id_idx        <= 5'd0;
			write_enable_latch           <= 1'b0; // R13
			wr_go         <= 1'b0;
			push          <= 1'b0;
			push_data     <= 8'h00;
			spi_dout_o    <= 1'b0;
			spi_dout_oe_o <= 1'b0;
			cmd_start_o   <= 1'b0;
			cmd_drop_o    <= 1'b0;
			cmd_op_o      <= 8'h00;
			cmd_addr_o    <= 20'h00000;
			sleep_enter_o <= 1'b0;
			sleep_exit_o  <= 1'b0;
			status_o      <= `SFC_ST_RESET;
			overrun_o     <= 1'b0;
		end
		else
		begin
			cmd_start_o   <= 1'b0;
			cmd_drop_o    <= 1'b0;
			sleep_enter_o <= 1'b0;
			sleep_exit_o  <= 1'b0;
			push          <= 1'b0;
			overrun_o     <= push & ~fifo_ready;
			status_o      <= stat_byte;
			if (sel_fall)
			begin
				state  <= ST_OPC;
				bit_i  <= 3'd0;
				byte_n <= 3'd0;
				obit   <= 3'd0;
				id_idx <= 5'd0;
				wr_go  <= 1'b0;
			end
			else if (sel_rise)
			begin
				state         <= ST_IDLE; // R7
				spi_dout_oe_o <= 1'b0;
				case (opc)
					`SFC_OP_WRITE_UNLOCK:
						if (aligned && byte_n == 3'd1)
							write_enable_latch <= 1'b1; // R10
					`SFC_OP_WRITE_LOCK:
						if (aligned && byte_n == 3'd1)
							write_enable_latch <= 1'b0; // R12 R13
					`SFC_OP_DEEP_SLEEP_ENTER:
						sleep_enter_o <= aligned && byte_n == 3'd1; // R8
					`SFC_OP_DEEP_SLEEP_EXIT:
						sleep_exit_o <= aligned && byte_n == 3'd1; // R8
					`SFC_OP_PAGE_REWRITE, `SFC_OP_PAGE_PROGRAM:
						if (wr_go && aligned && byte_n >= `SFC_WRITE_MIN_BYTES && !busy_i)
						begin
							cmd_start_o <= 1'b1; // R2 R11
							write_enable_latch         <= 1'b0; // R13
						end
						else
							cmd_drop_o <= wr_go; // R8 R9
					`SFC_OP_PAGE_CLEAR, `SFC_OP_REGION_WIPE_64K:
						if (aligned && byte_n == `SFC_ERASE_BYTES && write_enable_latch && !busy_i)
						begin
							cmd_start_o <= 1'b1; // R6 R11 R20
							write_enable_latch         <= 1'b0; // R13
						end
					default:
						write_enable_latch <= write_enable_latch; // R24
				endcase
			end
			else if (clk_rise && state != ST_IDLE)
			begin
				shin  <= byte_in[6:0];
				bit_i <= bit_i + 3'd1;
				if (byte_done)
				begin
					if (byte_n != 3'd7)
						byte_n <= byte_n + 3'd1;
					case (state)
						ST_OPC:
						begin
							opc <= byte_in; // R5
							src <= SRC_STAT;
							if (byte_in == `SFC_OP_STATUS_READ)
								state <= ST_OUT; // R17
							else if (byte_in == `SFC_OP_IDENTITY_READ)
							begin
								state <= busy_i ? ST_IGN : ST_OUT; // R16 R14
								src   <= SRC_ID;
							end
							else if (byte_in == `SFC_OP_ARRAY_READ || byte_in == `SFC_OP_FAST_READ)
								state <= busy_i ? ST_IGN : ST_ADDR; // R23 R9
							else if (sfc_is_modify(byte_in))
								state <= ST_ADDR; // R5
							else if (byte_in == `SFC_OP_WRITE_UNLOCK || byte_in == `SFC_OP_WRITE_LOCK ||
								byte_in == `SFC_OP_DEEP_SLEEP_ENTER || byte_in == `SFC_OP_DEEP_SLEEP_EXIT)
								state <= ST_DATA;
							else
								state <= ST_IGN; // R24
						end
						ST_ADDR:
						begin
							addr <= {addr[15:0], byte_in};
							if (byte_n == `SFC_ADDR_BYTES)
							begin
								cmd_op_o   <= opc;
								cmd_addr_o <= {addr[11:0], byte_in}; // R1 R21
								if (opc == `SFC_OP_ARRAY_READ)
								begin
									state <= ST_OUT;
									src   <= SRC_ARR;
								end
								else if (opc == `SFC_OP_FAST_READ)
									state <= ST_DUMMY; // R6
								else
									state <= ST_DATA;
							end
						end
						ST_DUMMY:
						begin
							state <= ST_OUT;
							src   <= SRC_ARR;
						end
						ST_DATA:
							if (opc == `SFC_OP_PAGE_REWRITE || opc == `SFC_OP_PAGE_PROGRAM)
							begin
								if (byte_n == `SFC_ERASE_BYTES)
									wr_go <= write_enable_latch && !busy_i; // R20 R9
								if ((byte_n == `SFC_ERASE_BYTES) ? (write_enable_latch && !busy_i) : wr_go)
								begin
									push      <= 1'b1;
									push_data <= byte_in;
								end
							end
						default:
							state <= state;
					endcase
				end
			end
			else if (clk_fall && state == ST_OUT)
			begin
				obit <= obit + 3'd1;
				if (obit == 3'd0)
				begin
					spi_dout_o    <= next_out[7]; // R3 R14
					osh           <= {next_out[6:0], 1'b0};
					spi_dout_oe_o <= 1'b1; // R7
					if (src == SRC_ID && id_idx != `SFC_ID_BYTES)
						id_idx <= id_idx + 5'd1;
					if (src == SRC_ARR)
						addr <= {4'h0, addr[19:0] + 20'h00001}; // R22
				end
				else
				begin
					spi_dout_o <= osh[7];
					osh        <= {osh[6:0], 1'b0};
				end
			end
		end
	end

	// ----------------------------------------
	// write data buffer
	// ----------------------------------------
	sfc_fifo #(
		.W  (8),
		.AW (FIFO_AW)
	) u_fifo (
		.ref_clk_i   (ref_clk_i),
		.arst_n_i    (arst_n_i),
		.in_data_i   (push_data),
		.in_valid_i  (push),
		.in_ready_o  (fifo_ready),
		.out_data_o  (wr_data_o),
		.out_valid_o (wr_valid_o),
		.out_ready_i (wr_ready_i)
	);
endmodule

// >>> sfc_spi_master.sv
// spi bus master model for the serial link
`timescale 1ns/1ps
module sfc_spi_master (
	// clock
	input  wire logic ref_clk_i,
	// serial link
	output logic      sel_n_o,
	output logic      sclk_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial
	begin
		sel_n_o = 1'b1;
		sclk_o  = 1'b0;
		mosi_o  = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// ----------------------------------------
	// one frame of n clocks, tx msb first
	// ----------------------------------------
	task automatic xfer(input int n, input logic [191:0] tx, output logic [191:0] rx);
		rx = '0;
		sel_n_o = 1'b0;
		wt(4);
		for (int i = 0; i < n; i++)
		begin
			mosi_o = tx[191 - i];
			wt(4);
			sclk_o = 1'b1;
			wt(4);
			rx = {rx[190:0], miso_i};
			sclk_o = 1'b0;
		end
		wt(4);
		sel_n_o = 1'b1;
		mosi_o  = ~mosi_o;
		wt(8);
	endtask
endmodule

// >>> sfc_front_end_asserts.sv
// port assertions of the serial flash command front end
`timescale 1ns/1ps
module sfc_front_end_asserts (
	// clock and reset
	input wire       ref_clk_i,
	input wire       arst_n_i,
	// observed ports
	input wire       spi_sel_n_i,
	input wire       spi_dout_oe_o,
	input wire       busy_i,
	input wire       cmd_start_o,
	input wire       sleep_enter_o,
	input wire       sleep_exit_o,
	input wire [7:0] status_o,
	input wire       overrun_o,
	input wire       wr_valid_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	status_zero_a: assert property (status_o[7:2] == 6'h00)
		else $error("status high bits set");
	status_busy_a: assert property (status_o[0] == $past(busy_i))
		else $error("status busy bit wrong");
	start_desel_a: assert property (cmd_start_o |-> spi_sel_n_i)
		else $error("start while selected");
	start_pulse_a: assert property (cmd_start_o |=> !cmd_start_o)
		else $error("start longer than one cycle");
	start_idle_a: assert property (cmd_start_o |-> !busy_i && (status_o[1] || $past(status_o[1])))
		else $error("start without latch or while busy");
	start_lock_a: assert property (cmd_start_o |-> ##[1:3] !status_o[1])
		else $error("latch not cleared after start");
	sleep_pulse_a: assert property (sleep_enter_o || sleep_exit_o |=> !sleep_enter_o && !sleep_exit_o)
		else $error("sleep pulse too long");
	oe_idle_a: assert property (spi_sel_n_i [*8] |-> !spi_dout_oe_o)
		else $error("output driven while deselected");
	oe_sel_a: assert property ($rose(spi_dout_oe_o) |-> !spi_sel_n_i)
		else $error("output enabled while deselected");
	wel_hold_a: assert property (spi_sel_n_i [*8] |=> $stable(status_o[1]))
		else $error("latch moved without a frame");
	overrun_full_a: assert property (overrun_o |-> wr_valid_o)
		else $error("overrun with empty fifo");
	cover property (cmd_start_o);
	cover property (overrun_o);
	cover property ($rose(spi_dout_oe_o));
	cover property (sleep_exit_o);
endmodule
bind sfc_front_end sfc_front_end_asserts asrt_u (.ref_clk_i, .arst_n_i, .spi_sel_n_i,
	.spi_dout_oe_o, .busy_i, .cmd_start_o, .sleep_enter_o, .sleep_exit_o, .status_o,
	.overrun_o, .wr_valid_o);

// >>> sfc_front_end_test.sv
// self-checking bench of the serial flash command front end
`timescale 1ns/1ps
`include "sfc_consts.vh"
module sfc_front_end_test;
	logic         ref_clk_i = 1'b0;
	logic         arst_n_i  = 1'b0;
	logic         busy      = 1'b0;
	logic         wr_ready  = 1'b0;
	logic         sel_n, sclk, mosi, dout, dout_oe, start, wr_valid, ovr, s_in, s_out, drop;
	logic [7:0]   op, wr_data, status;
	logic [19:0]  mem_addr, addr;
	logic [191:0] rx;
	logic [23:0]  a;
	logic [71:0]  d;
	logic [7:0]   mods [4] = '{`SFC_OP_PAGE_REWRITE, `SFC_OP_PAGE_PROGRAM,
		`SFC_OP_PAGE_CLEAR, `SFC_OP_REGION_WIPE_64K};
	int           n_mismatch, n_compared, n_start, n_ovr, n_oe, n_slp, e_start, k, j, ni, oe0;
	int           n_drop;
	wire          miso = dout_oe ? dout : ~dout;
	function automatic logic [7:0] mem_f(input logic [19:0] x);
		return x[7:0] ^ x[19:12];
	endfunction
	// identity codes below are arbitrary
	function automatic logic [7:0] id_f(input int i);
		return i == 0 ? 8'h96 : i == 1 ? 8'h69 : i == 2 ? 8'hC3 : i == 3 ? `SFC_ID_CFD_LEN : 8'h00;
	endfunction
	wire [7:0] mem_rdata = mem_f(mem_addr);
	always #12.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		n_start <= n_start + start;
		n_ovr   <= n_ovr + ovr;
		n_oe    <= n_oe + dout_oe;
		n_slp   <= n_slp + s_in + 16 * s_out;
		n_drop  <= n_drop + drop;
	end
	sfc_spi_master master_u (.ref_clk_i(ref_clk_i), .sel_n_o(sel_n), .sclk_o(sclk),
		.mosi_o(mosi), .miso_i(miso));
	sfc_front_end #(.MFR_CODE(8'h96), .TYPE_CODE(8'h69), .CAP_CODE(8'hC3)) dut_u (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .spi_sel_n_i(sel_n), .spi_clk_i(sclk),
		.spi_din_i(mosi), .spi_dout_o(dout), .spi_dout_oe_o(dout_oe), .mem_addr_o(mem_addr),
		.mem_rdata_i(mem_rdata), .busy_i(busy), .cmd_start_o(start), .cmd_drop_o(drop),
		.cmd_op_o(op), .cmd_addr_o(addr), .sleep_enter_o(s_in), .sleep_exit_o(s_out),
		.wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
		.status_o(status), .overrun_o(ovr));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic frame(input int n, input logic [191:0] t);
		master_u.xfer(n, t, rx);
	endtask
	task automatic cmd(input logic [7:0] o, input int n);
		frame(n, {o, 184'h0});
	endtask
	task automatic out(input int i0, input int n, input int i, input logic [7:0] e);
		chk("dout", e, rx[n - i0 - 1 - 8 * i -: 8]);
	endtask
	task automatic print_verdict;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#2000000;
		n_mismatch++;
		print_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(95));
		repeat (2) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk("status", `SFC_ST_RESET, status);
		cmd(`SFC_OP_WRITE_UNLOCK, 9);
		chk("wel", 0, status[1]);
		cmd(`SFC_OP_WRITE_UNLOCK, 8);
		chk("wel", 1, status[1]);
		oe0 = n_oe;
		cmd(8'h77, 16);
		chk("wel", 1, status[1]);
		chk("oe", oe0, n_oe);
		frame(24, {`SFC_OP_STATUS_READ, 184'h0});
		out(8, 24, 0, 8'h02);
		out(8, 24, 1, 8'h02);
		cmd(`SFC_OP_WRITE_LOCK, 8);
		chk("wel", 0, status[1]);
		wr_ready = 1'b1;
		for (k = 0; k < 4; k++)
		begin
			a = 24'($urandom);
			frame(k < 2 ? 40 : 32, {mods[k], a, 8'h5A, 152'h0});
			chk("start", e_start, n_start);
			cmd(`SFC_OP_WRITE_UNLOCK, 8);
			frame(k < 2 ? 40 : 32, {mods[k], a, 8'h5A, 152'h0});
			e_start++;
			chk("start", e_start, n_start);
			chk("op", mods[k], op);
			chk("addr", a[19:0], addr);
			chk("wel", 0, status[1]);
		end
		cmd(`SFC_OP_WRITE_UNLOCK, 8);
		frame(40, {`SFC_OP_PAGE_CLEAR, a, 160'h0});
		chk("start", e_start, n_start);
		wr_ready = 1'b0;
		a = 24'($urandom);
		d = {8'($urandom), $urandom, $urandom};
		frame(104, {`SFC_OP_PAGE_REWRITE, a, d, 88'h0});
		e_start++;
		chk("start", e_start, n_start);
		chk("overrun", 1, n_ovr);
		for (k = 0; k < 8; k++)
		begin
			chk("wr_data", d[71 - 8 * k -: 8], wr_data);
			wr_ready = 1'b1;
			@(negedge ref_clk_i);
			wr_ready = 1'b0;
		end
		chk("wr_valid", 0, wr_valid);
		busy = 1'b1;
		@(negedge ref_clk_i);
		frame(16, {`SFC_OP_STATUS_READ, 184'h0});
		out(8, 16, 0, 8'h01);
		oe0 = n_oe;
		cmd(`SFC_OP_WRITE_UNLOCK, 8);
		frame(32, {`SFC_OP_PAGE_CLEAR, a, 160'h0});
		frame(48, {`SFC_OP_ARRAY_READ, a, 160'h0});
		cmd(`SFC_OP_IDENTITY_READ, 24);
		chk("oe", oe0, n_oe);
		chk("start", e_start, n_start);
		busy = 1'b0;
		cmd(`SFC_OP_IDENTITY_READ, 176);
		for (k = 0; k < 21; k++)
			out(8, 176, k, id_f(k));
		for (k = 0; k < 2; k++)
		begin
			a = 24'($urandom);
			if (k == 0)
				a[19:0] = 20'hFFFFE;
			ni = 32 + 8 * k;
			frame(ni + 24, {k ? `SFC_OP_FAST_READ : `SFC_OP_ARRAY_READ, a, 8'hC3, 152'h0});
			for (j = 0; j < 3; j++)
				out(ni, ni + 24, j, mem_f(a[19:0] + 20'(j)));
		end
		for (k = 0; k < 2; k++)
		begin
			cmd(k ? `SFC_OP_DEEP_SLEEP_EXIT : `SFC_OP_DEEP_SLEEP_ENTER, 12);
			cmd(k ? `SFC_OP_DEEP_SLEEP_EXIT : `SFC_OP_DEEP_SLEEP_ENTER, 8);
		end
		chk("sleep", 17, n_slp);
		frame(44, {`SFC_OP_PAGE_PROGRAM, a, 8'h5A, 152'h0});
		chk("drop", 1, n_drop);
		chk("start", e_start, n_start);
		chk("wel", 1, status[1]);
		chk("wr_data", 8'h5A, wr_data);
		print_verdict();
	end
endmodule
